/* hw/eac_defines.svh */
`ifndef EAC_DEFINES_SVH
`define EAC_DEFINES_SVH

// Register offsets in the processor I/O space
`define EAC_OFS_CTRL      6'h1c
`define EAC_OFS_DATA      6'h1d
`define EAC_OFS_ADDR_LOW  6'h1e
`define EAC_OFS_ADDR_HIGH 6'h1f

// Control register bit positions
`define EAC_BIT_RIE 3
`define EAC_BIT_MWE 2
`define EAC_BIT_WE  1
`define EAC_BIT_RE  0

// Array geometry
`define EAC_ARRAY_DEPTH 512
`define EAC_ADDR_MSB    8

// Cycle counts
`define EAC_MWE_CYCLES 3'd4
`define EAC_WR_STALL   3'd2
`define EAC_RD_STALL   3'd4

// Self-timed programming time and clock rate
`define EAC_WRITE_TIME_US 4000
`define EAC_CLK_MHZ       100

`endif

/* hw/eac_pkg.sv */
package eac_pkg;

  // One processor I/O access
  typedef struct packed {
    logic [5:0] addr;   // I/O space offset
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
    logic [7:0] wdata;  // Write data
  } eac_io_req_t;

  // Controller state
  typedef enum logic [1:0] {
    EAC_ST_IDLE = 2'b00,
    EAC_ST_READ = 2'b01,
    EAC_ST_PROG = 2'b10
  } eac_state_t;

endpackage : eac_pkg

/* hw/eac_nv_array.sv */
`timescale 1ns/100ps
`default_nettype none

`include "eac_defines.svh"

// Byte array with registered read port
module eac_nv_array (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       wen_i,
  input  wire logic [8:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);

  // Storage, contents survive reset
  logic [7:0] mem_q [`EAC_ARRAY_DEPTH];
  logic [7:0] rdata_q;  // Read register
  logic [7:0] rdata_d;  // Its next value

  // Read path follows the address every cycle
  always_comb begin
    rdata_d = mem_q[addr_i];
  end

  // Program one byte, register the read
  always_ff @(posedge mclk_i) begin
    if (wen_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule : eac_nv_array

`default_nettype wire

/* hw/eac_ctrl.sv */
// Operation
// - 9-bit linear address, top bit in high
// - Data register feeds writes, receives reads
// - Control bits 7..4 read zero
// - Ready interrupt while enabled and not busy
// - Master write enable self-clears after four cycles
// - Write strobe starts programming only with enable
// - Write strobe held until programming time ends
// - Write start stalls processor two cycles
// - Read strobe loads data, clears itself
// - Read start stalls processor four cycles
// - Address or data write aborts programming
`timescale 1ns/100ps
`default_nettype none

`include "eac_defines.svh"

module eac_ctrl #(
  // Programming time in clock cycles
  parameter int unsigned WRITE_CYCLES = `EAC_WRITE_TIME_US * `EAC_CLK_MHZ
) (
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire eac_pkg::eac_io_req_t io_req_i,
  input  wire logic                global_irq_en_i,
  output logic               [7:0] io_rdata_o,
  output logic                     cpu_stall_o,
  output logic                     ready_irq_o
);

  // Architectural state
  eac_pkg::eac_state_t state_q, state_d;  // Controller state
  logic [8:0]  addr_q, addr_d;            // Linear byte address
  logic [7:0]  data_q, data_d;            // Data byte
  logic        rie_q, rie_d;              // Ready interrupt enable
  logic        mwe_q, mwe_d;              // Master write enable
  logic [2:0]  mwe_cnt_q, mwe_cnt_d;      // Enable lifetime
  logic [2:0]  stall_cnt_q, stall_cnt_d;  // Stall cycles left
  logic [19:0] prog_cnt_q, prog_cnt_d;    // Programming cycles left
  logic [7:0]  rdata_q, rdata_d;          // Read data output
  logic        stall_q, stall_d;          // Stall output
  logic        irq_q, irq_d;              // Interrupt output

  // Array hookup
  logic        arr_wen;                   // Program strobe
  logic [7:0]  arr_rdata;                 // Byte at current address

  // Decoded accesses
  logic wr_ctrl, wr_data, wr_alo, wr_ahi;
  logic we_bit, re_bit;
  logic start_wr, start_rd, abort;

  // Status bits as software sees them
  assign we_bit = (state_q == eac_pkg::EAC_ST_PROG);
  assign re_bit = (state_q == eac_pkg::EAC_ST_READ);

  // Write decode of one offset
  function automatic logic hit_wr(input eac_pkg::eac_io_req_t r,
                                  input logic [5:0] ofs);
    hit_wr = r.wr && (r.addr == ofs);
  endfunction : hit_wr

  assign wr_ctrl = hit_wr(io_req_i, `EAC_OFS_CTRL);
  assign wr_data = hit_wr(io_req_i, `EAC_OFS_DATA);
  assign wr_alo  = hit_wr(io_req_i, `EAC_OFS_ADDR_LOW);
  assign wr_ahi  = hit_wr(io_req_i, `EAC_OFS_ADDR_HIGH);

  // Write only starts with master enable up and array idle
  assign start_wr = wr_ctrl && io_req_i.wdata[`EAC_BIT_WE] && mwe_q
                    && (state_q == eac_pkg::EAC_ST_IDLE);
  // Read only starts when idle; a write strobe wins
  assign start_rd = wr_ctrl && io_req_i.wdata[`EAC_BIT_RE] && !start_wr
                    && (state_q == eac_pkg::EAC_ST_IDLE);
  // Touching address or data while programming kills it
  assign abort = we_bit && (wr_data || wr_alo || wr_ahi);
  // Program at the end of an unaborted programming time
  assign arr_wen = we_bit && (prog_cnt_q == 20'h00001) && !abort;

  // Next-state logic for all registers except the stall and interrupt outputs
  always_comb begin
    state_d     = state_q;
    addr_d      = addr_q;
    data_d      = data_q;
    rie_d       = rie_q;
    mwe_d       = mwe_q;
    mwe_cnt_d   = mwe_cnt_q;
    stall_cnt_d = stall_cnt_q;
    prog_cnt_d  = prog_cnt_q;
    rdata_d     = rdata_q;
    // Address registers, upper bits not stored
    if (wr_alo) begin
      addr_d[7:0] = io_req_i.wdata;
    end
    if (wr_ahi) begin
      addr_d[`EAC_ADDR_MSB] = io_req_i.wdata[0];
    end
    // Data register from software
    if (wr_data) begin
      data_d = io_req_i.wdata;
    end
    // Control register write
    if (wr_ctrl) begin
      rie_d = io_req_i.wdata[`EAC_BIT_RIE];
    end
    // Master enable timeout counter
    if (mwe_q) begin
      mwe_cnt_d = mwe_cnt_q - 3'd1;
      if (mwe_cnt_q == 3'd1) begin
        mwe_d = 1'b0;
      end
    end else if (wr_ctrl && io_req_i.wdata[`EAC_BIT_MWE]
                 && !io_req_i.wdata[`EAC_BIT_WE]) begin
      mwe_d     = 1'b1;
      mwe_cnt_d = `EAC_MWE_CYCLES;
    end
    // Stall countdown
    if (stall_cnt_q != 3'd0) begin
      stall_cnt_d = stall_cnt_q - 3'd1;
    end
    unique case (state_q)
      // Waiting for a strobe
      eac_pkg::EAC_ST_IDLE: begin
        if (start_wr) begin
          state_d     = eac_pkg::EAC_ST_PROG;
          prog_cnt_d  = WRITE_CYCLES[19:0];
          stall_cnt_d = `EAC_WR_STALL;
        end else if (start_rd) begin
          state_d     = eac_pkg::EAC_ST_READ;
          stall_cnt_d = `EAC_RD_STALL;
        end
      end
      // Read held for the stall, byte taken on the last cycle
      eac_pkg::EAC_ST_READ: begin
        if (stall_cnt_q == 3'd1) begin
          data_d  = arr_rdata;
          state_d = eac_pkg::EAC_ST_IDLE;
        end
      end
      // Self-timed programming
      eac_pkg::EAC_ST_PROG: begin
        prog_cnt_d = prog_cnt_q - 20'h00001;
        if (abort || (prog_cnt_q == 20'h00001)) begin
          state_d    = eac_pkg::EAC_ST_IDLE;
          prog_cnt_d = 20'h00000;
        end
      end
      default: begin
        state_d = eac_pkg::EAC_ST_IDLE;
      end
    endcase
    // Register read data
    if (io_req_i.rd) begin
      unique case (io_req_i.addr)
        `EAC_OFS_ADDR_LOW:  rdata_d = addr_q[7:0];
        `EAC_OFS_ADDR_HIGH: rdata_d = {7'h00, addr_q[`EAC_ADDR_MSB]};
        `EAC_OFS_DATA:      rdata_d = data_q;
        `EAC_OFS_CTRL:      rdata_d = {4'h0, rie_q, mwe_q, we_bit, re_bit};
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  // Output flops follow their causes
  always_comb begin
    stall_d = (stall_cnt_d != 3'd0);
    irq_d   = rie_d && global_irq_en_i
              && (state_d != eac_pkg::EAC_ST_PROG);
  end

  // Register everything
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q     <= eac_pkg::EAC_ST_IDLE;
      addr_q      <= 9'h000;
      data_q      <= 8'h00;
      rie_q       <= 1'b0;
      mwe_q       <= 1'b0;
      mwe_cnt_q   <= 3'd0;
      stall_cnt_q <= 3'd0;
      prog_cnt_q  <= 20'h00000;
      rdata_q     <= 8'h00;
      stall_q     <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      addr_q      <= addr_d;
      data_q      <= data_d;
      rie_q       <= rie_d;
      mwe_q       <= mwe_d;
      mwe_cnt_q   <= mwe_cnt_d;
      stall_cnt_q <= stall_cnt_d;
      prog_cnt_q  <= prog_cnt_d;
      rdata_q     <= rdata_d;
      stall_q     <= stall_d;
      irq_q       <= irq_d;
    end
  end

  assign io_rdata_o  = rdata_q;
  assign cpu_stall_o = stall_q;
  assign ready_irq_o = irq_q;

  // Storage array
  eac_nv_array u_array (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .wen_i   (arr_wen),
    .addr_i  (addr_q),
    .wdata_i (data_q),
    .rdata_o (arr_rdata)
  );

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_wr_stall;
    cpu_stall_o [*2] ##1 !cpu_stall_o;
  endsequence

  sequence s_rd_done;
    re_bit [*4] ##1 (!re_bit && data_q == $past(arr_rdata));
  endsequence

  a_mwe_timeout: assert property ($rose(mwe_q) |-> mwe_q [*4] ##1 !mwe_q)
    else $error("master write enable did not last four cycles");
  a_wr_needs_mwe: assert property (
    (wr_ctrl && io_req_i.wdata[`EAC_BIT_WE] && !mwe_q && !we_bit) |=> !we_bit)
    else $error("programming started without master enable");
  a_wr_stall_two: assert property (start_wr |=> we_bit ##0 s_wr_stall)
    else $error("write stall not two cycles");
  a_rd_stall_four: assert property (
    start_rd |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall not four cycles");
  a_rd_self_clear: assert property (start_rd |=> s_rd_done)
    else $error("read strobe or data wrong");
  a_ctrl_reserved: assert property (
    (io_req_i.rd && io_req_i.addr == `EAC_OFS_CTRL) |=> io_rdata_o[7:4] == 4'h0)
    else $error("reserved control bits not zero");
  a_addr_high_ro: assert property (
    (io_req_i.rd && io_req_i.addr == `EAC_OFS_ADDR_HIGH)
    |=> io_rdata_o[7:1] == 7'h00)
    else $error("high address upper bits not zero");
  a_irq_busy_off: assert property (we_bit |-> !ready_irq_o)
    else $error("ready interrupt while programming");
  a_prog_end: assert property (arr_wen |=> !we_bit && !cpu_stall_o)
    else $error("write strobe not cleared after programming");
  a_abort_stop: assert property (abort |=> !we_bit && $stable(arr_rdata) [*1])
    else $error("programming not aborted");

endmodule : eac_ctrl

`default_nettype wire

/* tb/eac_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none

`include "eac_defines.svh"

// Compare a bench expectation with what the block shows
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", nm, exp, got); end end

module eac_ctrl_bench;
  localparam int unsigned WCYC = 20;  // Shortened programming time

  logic                 mclk_i;       // Bench clock
  logic                 reset_i;      // Synchronous reset
  logic                 gie;          // Global interrupt flag
  eac_pkg::eac_io_req_t req;          // Processor I/O access
  logic           [7:0] rdata;        // Read data from block
  logic                 stall;        // Processor stall
  logic                 irq;          // Ready interrupt
  int                   bad_count;    // Mismatches seen
  int                   check_count;  // Comparisons made
  int                   seed;         // Random seed
  int                   cyc = 0;      // Cycles run so far
  int                   n;            // Counted cycles
  logic           [7:0] mem [512];    // Expected array contents
  logic           [8:0] adrs [6];     // Addresses used in the sweep
  logic           [7:0] got;          // Value read back

  eac_ctrl #(.WRITE_CYCLES(WCYC)) u_dut (
    .mclk_i          (mclk_i),
    .reset_i         (reset_i),
    .io_req_i        (req),
    .global_irq_en_i (gie),
    .io_rdata_o      (rdata),
    .cpu_stall_o     (stall),
    .ready_irq_o     (irq)
  );

  // Free running clock, 10 ns period
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Cut a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end

  // One register write, held for one taken edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk_i);
    req <= '0;
  endtask : wr

  // One register read, data settles after the taken edge
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge mclk_i);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk_i);
    req <= '0;
    #1 q = rdata;
  endtask : rd

  // Count cycles a flag stays at a level, stall or interrupt
  task automatic cnt(input logic lvl, input logic use_irq, output int k);
    k = 0;
    #1;
    while (((use_irq ? irq : stall) === lvl) && k < 100) begin
      k++;
      @(posedge mclk_i);
      #1;
    end
  endtask : cnt

  // Load the address pair
  task automatic set_adr(input logic [8:0] a);
    wr(`EAC_OFS_ADDR_LOW, a[7:0]);
    wr(`EAC_OFS_ADDR_HIGH, {7'h00, a[8]});
  endtask : set_adr

  // Program one byte, optionally aborting it mid-way
  task automatic prog(input logic [8:0] a, input logic [7:0] d,
                      input logic ab);
    int k;
    logic [7:0] q;
    // Interrupts masked across the guarded sequence
    @(posedge mclk_i);
    gie <= 1'b0;
    set_adr(a);
    wr(`EAC_OFS_DATA, d);
    wr(`EAC_OFS_CTRL, 8'h0c);
    wr(`EAC_OFS_CTRL, 8'h0a);
    gie <= 1'b1;
    cnt(1'b1, 1'b0, k);
    `CHK("write stall", 2, k)
    rd(`EAC_OFS_CTRL, q);
    `CHK("busy bit", 8'h0a, q)
    if (ab) begin
      @(posedge mclk_i);
      wr(`EAC_OFS_DATA, ~d);
      cnt(1'b0, 1'b1, k);
      `CHK("abort", 1'b1, k <= 1)
    end else begin
      cnt(1'b0, 1'b1, k);
      `CHK("busy cycles", WCYC - 4, k)
    end
  endtask : prog

  // Read one byte through the read strobe
  task automatic fetch(input logic [8:0] a, output logic [7:0] q);
    int k;
    set_adr(a);
    wr(`EAC_OFS_CTRL, 8'h09);
    cnt(1'b1, 1'b0, k);
    `CHK("read stall", 4, k)
    rd(`EAC_OFS_CTRL, q);
    `CHK("read strobe clear", 8'h08, q)
    rd(`EAC_OFS_DATA, q);
  endtask : fetch

  // Main sequence
  initial begin
    seed = 43;
    bad_count = 0;
    check_count = 0;
    req = '0;
    gie = 1'b1;
    reset_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(`EAC_OFS_CTRL, got);
    `CHK("ctrl reset", 8'h00, got)
    rd(6'h10, got);
    `CHK("unmapped", 8'h00, got)
    wr(`EAC_OFS_ADDR_HIGH, 8'hff);
    rd(`EAC_OFS_ADDR_HIGH, got);
    `CHK("addr high", 8'h01, got)
    wr(`EAC_OFS_CTRL, 8'hf8);
    rd(`EAC_OFS_CTRL, got);
    `CHK("ctrl upper", 8'h08, got)
    `CHK("irq on", 1'b1, irq)
    @(posedge mclk_i);
    gie <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 `CHK("irq masked", 1'b0, irq)
    @(posedge mclk_i);
    gie <= 1'b1;
    $display("test registers done");
    // Enable written together with the strobe must not take
    wr(`EAC_OFS_CTRL, 8'h0e);
    rd(`EAC_OFS_CTRL, got);
    `CHK("mwe with strobe", 8'h08, got)
    // Strobe on the last cycle the enable stands still starts
    wr(`EAC_OFS_CTRL, 8'h0c);
    repeat (2) @(posedge mclk_i);
    wr(`EAC_OFS_CTRL, 8'h0a);
    cnt(1'b1, 1'b0, n);
    `CHK("last strobe", 2, n)
    cnt(1'b0, 1'b1, n);
    `CHK("last strobe busy", WCYC - 2, n)
    // Strobe after the enable has timed out is ignored
    wr(`EAC_OFS_CTRL, 8'h0c);
    repeat (4) @(posedge mclk_i);
    wr(`EAC_OFS_CTRL, 8'h0a);
    cnt(1'b1, 1'b0, n);
    `CHK("late strobe", 0, n)
    rd(`EAC_OFS_CTRL, got);
    `CHK("mwe expired", 8'h08, got)
    $display("test enable timeout done");
    for (int i = 0; i < 6; i++) begin
      adrs[i] = (i == 0) ? 9'h0ff : (i == 1) ? 9'h1ff : 9'($random(seed));
      mem[adrs[i]] = 8'($random(seed));
      prog(adrs[i], mem[adrs[i]], 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      fetch(adrs[i], got);
      `CHK("array byte", mem[adrs[i]], got)
    end
    $display("test program sweep done");
    prog(adrs[2], ~mem[adrs[2]], 1'b1);
    fetch(adrs[2], got);
    `CHK("aborted byte", mem[adrs[2]], got)
    $display("test abort done");
    conclude();
  end

endmodule : eac_ctrl_bench

`default_nettype wire
